// ===== bench/lec_logic_cell_monitor.sv
// port checks for the logic cell
`timescale 1ns/1ps
`default_nettype none
module lec_logic_cell_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic carry_zero_path_in,
  input wire logic carry_one_path_in,
  input wire logic carry_zero_path_out,
  input wire logic carry_one_path_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // one of the three decoded words
  logic mapped;
  assign mapped = paddr == lec_pkg::LEC_LUT_OFS ||
    paddr == lec_pkg::LEC_MODE_OFS || paddr == lec_pkg::LEC_STAT_OFS;
  ////////////////////////////////////////////////////////////////////////
  chk_ready_one_cycle:
    assert property (pready |=> !pready) else $error("pready too long");
  chk_setup_answers:
    assert property (psel && !penable && !pready |=> pready)
    else $error("no answer to setup");
  chk_ready_cause:
    assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  chk_err_with_ready:
    assert property (pslverr |-> pready) else $error("lone pslverr");
  chk_rdata_idle:
    assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not idle");
  chk_mapped_no_err:
    assert property (pready && $past(mapped) |-> !pslverr)
    else $error("error on mapped word");
  chk_lut_upper_zero:
    assert property (pready && !pwrite && $past(paddr) == lec_pkg::LEC_LUT_OFS
      |-> prdata[31:16] == 16'h0000) else $error("mask upper bits set");
  chk_carry_split:
    assert property (carry_zero_path_out != carry_one_path_out
      |-> carry_zero_path_in != carry_one_path_in) else $error("carry split");
endmodule : lec_logic_cell_monitor
bind lec_logic_cell lec_logic_cell_monitor lec_logic_cell_monitor_inst (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .carry_zero_path_in(carry_zero_path_in),
  .carry_one_path_in(carry_one_path_in),
  .carry_zero_path_out(carry_zero_path_out),
  .carry_one_path_out(carry_one_path_out));
`default_nettype wire

// ===== bench/lec_logic_cell_tb.sv
// self-checking bench for the logic cell
`timescale 1ns/1ps
`default_nettype none
module lec_logic_cell_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, er;
  logic [3:0] li = 4'h0; // lookup inputs d c b a
  logic [4:0] ctl = 5'h00; // enable, clear, aload, sclear, sload
  logic ans = 1'b1, cci = 1'b0, cen = 1'b0, cup = 1'b1;
  logic na = 1'b0, nb = 1'b0, c0i, c1i, c0o, c1o, ra, rb, lo, s, c;
  int err_count = 0;
  int comparisons = 0;
  always #25 clock = ~clock;
  lec_neighbour_model lec_neighbour_model_inst (.op_a(na), .op_b(nb),
    .carry_zero(c0i), .carry_one(c1i));
  lec_logic_cell lec_logic_cell_inst (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lookup_input_a(li[0]),
    .lookup_input_b(li[1]), .lookup_input_c(li[2]),
    .lookup_input_d(li[3]), .clock_enable(ctl[4]), .cell_clear(ctl[3]),
    .aload_preset(ctl[2]), .sync_clear(ctl[1]), .sync_load(ctl[0]),
    .add_not_sub(ans), .cluster_carry_in(cci), .counter_enable(cen),
    .count_up(cup), .carry_zero_path_in(c0i), .carry_one_path_in(c1i),
    .carry_zero_path_out(c0o), .carry_one_path_out(c1o),
    .route_out_a(ra), .route_out_b(rb), .local_out(lo));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %0t bit %b exp %b", $time, g, e);
    end
  endtask : chk1
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %0t word %h exp %h", $time, g, e);
    end
  endtask : chk32
  // one apb transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    n = 0;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
    // a slave that never answers counts as a mismatch
    if (n >= 20)
    begin
      err_count++;
      $display("FAIL %0t apb transfer never answered", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // held two edges, so only idempotent controls go through here
  task automatic st(input logic [3:0] v, input logic [4:0] k);
    @(posedge clock);
    li <= v;
    ctl <= k;
    @(posedge clock);
    @(negedge clock);
  endtask : st
  task automatic summarize();
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, lec_pkg::LEC_MODE_OFS, 32'h00000000);
    chk32(rd, 32'(lec_pkg::LEC_MODE_RST));
    apb(1'b0, 8'h0C, 32'h00000000);
    chk1(er, 1'b1);
    // arbitrary mask walked over all sixteen input codes
    apb(1'b1, lec_pkg::LEC_LUT_OFS, 32'h0000B2C5);
    apb(1'b0, lec_pkg::LEC_LUT_OFS, 32'h00000000);
    chk32(rd, 32'h0000B2C5);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clock) li <= 4'(i);
      @(negedge clock) chk1(ra, 1'(16'hB2C5 >> i));
      chk1(lo, 1'(16'hB2C5 >> i));
    end
    apb(1'b1, lec_pkg::LEC_LUT_OFS, 32'h0000FFFF);
    for (int t = 0; t < 4; t++)
    begin
      apb(1'b1, lec_pkg::LEC_MODE_OFS, 32'h000001C0 | 32'(t));
      li <= 4'h8;
      ctl <= 5'h18;
      @(posedge clock) ctl <= 5'h10;
      @(posedge clock);
      @(negedge clock) chk1(ra, 1'b1);
      @(negedge clock) chk1(ra, 1'(4'b1001 >> t));
    end
    apb(1'b1, lec_pkg::LEC_MODE_OFS, 32'h00000080);
    apb(1'b1, lec_pkg::LEC_LUT_OFS, 32'h00000002);
    st(4'h1, 5'h10);
    chk1(rb, 1'b1);
    st(4'h0, 5'h00);
    chk1(rb, 1'b1);
    chk1(ra, 1'b0);
    chk1(lo, 1'b0);
    st(4'h0, 5'h08);
    chk1(rb, 1'b0);
    st(4'h4, 5'h04);
    chk1(rb, 1'b1);
    st(4'h4, 5'h03);
    chk1(rb, 1'b1);
    st(4'h4, 5'h13);
    chk1(rb, 1'b0);
    st(4'h4, 5'h11);
    chk1(rb, 1'b1);
    apb(1'b1, lec_pkg::LEC_MODE_OFS, 32'h000000A0);
    st(4'h0, 5'h08);
    st(4'h0, 5'h04);
    chk1(rb, 1'b1);
    // chain start: add and subtract from the cluster select
    apb(1'b1, lec_pkg::LEC_MODE_OFS, 32'h00000014);
    ctl <= 5'h00;
    // bit 3 walks the direction too: down-count flips the inversion of operand b
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clock) ans <= k[2];
      cup <= k[3];
      li <= {2'b00, k[1], k[0]};
      c = k[3] ? (k[2] ? (k[0] & k[1]) : (k[0] | ~k[1])) :
        (k[2] ? (k[0] & ~k[1]) : (k[0] | k[1]));
      @(negedge clock) chk1(ra, k[0] ^ k[1] ^ ~k[3]);
      chk1(c0o, c);
      chk1(c1o, c);
    end
    apb(1'b1, lec_pkg::LEC_MODE_OFS, 32'h00000004);
    ans <= 1'b1;
    cup <= 1'b1;
    for (int k = 0; k < 32; k++)
    begin
      @(posedge clock) li <= {2'b00, k[1], k[0]};
      na <= k[2];
      nb <= k[3];
      cci <= k[4];
      c = (k[0] & k[1]) | (k[2] & k[3] & (k[0] | k[1]));
      s = k[0] ^ k[1] ^ (k[4] ? (k[2] | k[3]) : (k[2] & k[3]));
      @(negedge clock) chk1(c0o, c);
      chk1(c1o, (k[0] & k[1]) | ((k[2] | k[3]) & (k[0] | k[1])));
      chk1(ra, s);
    end
    // counter from feedback: five enabled edges toggle to one
    apb(1'b1, lec_pkg::LEC_MODE_OFS, 32'h0000011C);
    cci <= 1'b0;
    st(4'h2, 5'h08);
    chk1(lo, 1'b0);
    @(posedge clock) cen <= 1'b1;
    ctl <= 5'h10;
    repeat (5) @(posedge clock);
    cen <= 1'b0;
    @(negedge clock) chk1(lo, 1'b1);
    repeat (3) @(posedge clock);
    @(negedge clock) chk1(lo, 1'b1);
    // status: register 1, sum 0, both carries 1
    apb(1'b0, lec_pkg::LEC_STAT_OFS, 32'h00000000);
    chk32(rd, 32'h0000000D);
    summarize();
  end
  // watchdog well beyond the under two hundred cycles of the tests
  initial
  begin
    repeat (4000) @(posedge clock);
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end
endmodule : lec_logic_cell_tb
`default_nettype wire

// ===== bench/lec_neighbour_model.sv
// lower-order neighbour cell feeding the carry pair
`timescale 1ns/1ps
`default_nettype none
module lec_neighbour_model (
  input wire logic op_a,
  input wire logic op_b,
  output logic carry_zero,
  output logic carry_one
);
  // carry for an assumed carry-in of 0 and of 1
  assign carry_zero = op_a & op_b;
  assign carry_one = op_a | op_b;
endmodule : lec_neighbour_model
`default_nettype wire

// ===== hw/lec_logic_cell.sv
// one programmable logic cell with apb configuration port
`timescale 1ns/1ps
`default_nettype none
module lec_logic_cell (
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lookup inputs
  input wire logic lookup_input_a,
  input wire logic lookup_input_b,
  input wire logic lookup_input_c,
  input wire logic lookup_input_d,
  // register controls
  input wire logic clock_enable,
  input wire logic cell_clear,
  input wire logic aload_preset,
  // cluster-wide controls
  input wire logic sync_clear,
  input wire logic sync_load,
  input wire logic add_not_sub,
  input wire logic cluster_carry_in,
  // per-cell counter controls from local interconnect
  input wire logic counter_enable,
  input wire logic count_up,
  // carry-select chain
  input wire logic carry_zero_path_in,
  input wire logic carry_one_path_in,
  output logic carry_zero_path_out,
  output logic carry_one_path_out,
  // cell outputs
  output logic route_out_a,
  output logic route_out_b,
  output logic local_out
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [15:0] lut_mask_q; // lookup truth table
  logic [8:0] mode_q; // register type, mode and output selects
  logic q_q; // the storage register
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // decoded configuration fields
  logic arith_en;
  logic fbk_en;
  logic chain_start;
  logic preset_mode;
  logic [2:0] out_sel;
  lec_pkg::lec_ff_e ff_kind;

  assign ff_kind = lec_pkg::lec_ff_e'(mode_q[lec_pkg::LEC_FF_LSB +: 2]);
  assign arith_en = mode_q[lec_pkg::LEC_ARITH_BIT];
  assign fbk_en = mode_q[lec_pkg::LEC_FBK_BIT];
  assign chain_start = mode_q[lec_pkg::LEC_CHAIN_BIT];
  assign preset_mode = mode_q[lec_pkg::LEC_PRESET_BIT];
  assign out_sel = mode_q[lec_pkg::LEC_SEL_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // two-input carry generate/propagate select, used by both paths
  function automatic logic carry_of(input logic a, input logic b,
                                    input logic cin);
    carry_of = (a & b) | (cin & (a | b));
  endfunction : carry_of

  // register address decode, used for reads and writes
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == lec_pkg::LEC_LUT_OFS) ||
                (addr == lec_pkg::LEC_MODE_OFS) ||
                (addr == lec_pkg::LEC_STAT_OFS);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // lookup function

  logic lut_a; // first index bit, may be the register itself
  logic [3:0] lut_idx;
  logic lut_out;

  // packing: own register replaces input a so a lut can consume it
  assign lut_a = fbk_en ? q_q : lookup_input_a;
  // input d is the top index bit of the sixteen-entry mask
  assign lut_idx = {lookup_input_d, lookup_input_c, lookup_input_b, lut_a};
  assign lut_out = lut_mask_q[lut_idx];

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic path

  logic sub_invert; // invert operand b for subtract or count down, but not both
  logic op_b;
  logic cin0; // effective zero-path carry
  logic cin1; // effective one-path carry
  logic sum0;
  logic sum1;
  logic sum_out;

  // subtract or down-count alone means adding the complement; together they cancel
  assign sub_invert = ~add_not_sub ^ ~count_up;
  assign op_b = lookup_input_b ^ sub_invert;
  // at the first cell the select line is the carry, giving the +1 of
  // a two's complement subtract; later cells take the chain
  assign cin0 = chain_start ? ~add_not_sub : carry_zero_path_in;
  assign cin1 = chain_start ? ~add_not_sub : carry_one_path_in;
  assign sum0 = lut_a ^ op_b ^ cin0;
  assign sum1 = lut_a ^ op_b ^ cin1;
  // cluster carry-in picks which precomputed chain forms the sum
  assign sum_out = cluster_carry_in ? sum1 : sum0;

  // each path's carry-in selects between precomputed candidates
  // from operands a and b; chain carries are combinational so a long
  // chain settles within one clock period
  always_comb
  begin
    if (arith_en)
    begin
      carry_zero_path_out = carry_of(lut_a, op_b, cin0);
      carry_one_path_out = carry_of(lut_a, op_b, cin1);
    end
    else
    begin
      // chain idles low outside arithmetic mode
      carry_zero_path_out = 1'b0;
      carry_one_path_out = 1'b0;
    end
  end

  // unregistered result: lookup or sum, never through the register
  logic comb_out;
  assign comb_out = arith_en ? sum_out : lut_out;

  ////////////////////////////////////////////////////////////////////////////
  // storage register

  logic q_d; // clocked next value
  logic ff_d; // value the configured flip-flop type produces

  // flip-flop type: lookup drives d/t/j/s, input d drives k/r
  always_comb
  begin
    case (ff_kind)
      lec_pkg::LEC_FF_D: ff_d = comb_out;
      lec_pkg::LEC_FF_T: ff_d = q_q ^ comb_out;
      lec_pkg::LEC_FF_JK: ff_d = (comb_out & ~q_q) | (~lookup_input_d & q_q);
      lec_pkg::LEC_FF_SR: ff_d = comb_out | (q_q & ~lookup_input_d);
      default: ff_d = q_q;
    endcase
  end

  // synchronous next value under clock enable
  always_comb
  begin
    q_d = q_q;
    if (clock_enable)
    begin
      if (sync_clear)
        q_d = 1'b0;
      else if (sync_load)
        q_d = lookup_input_c;
      else if (arith_en)
      begin
        // counting only while this cell's enable is up
        if (counter_enable)
          q_d = sum_out;
      end
      else
        q_d = ff_d;
    end
  end

  // clear and load/preset override the clock enable; with one clock
  // domain they land on the next edge rather than at once
  always_ff @(posedge clock)
  begin
    if (!resetn)
      q_q <= 1'b0;
    else if (cell_clear)
      q_q <= 1'b0;
    else if (aload_preset)
      q_q <= preset_mode ? 1'b1 : lookup_input_c;
    else
      q_q <= q_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // cell outputs: each picks unregistered or registered independently
  // these stay combinational so the bypass path has no added latency

  assign route_out_a = out_sel[0] ? q_q : comb_out;
  assign route_out_b = out_sel[1] ? q_q : comb_out;
  assign local_out = out_sel[2] ? q_q : comb_out;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase after each setup

  logic setup_ph; // setup cycle of a new transfer
  logic wr_acc; // write completing this edge
  assign setup_ph = psel & ~penable & ~pready_q;
  assign wr_acc = psel & penable & pready_q & pwrite;

  // ready is raised for exactly the access cycle
  always_ff @(posedge clock)
  begin
    if (!resetn)
      pready_q <= 1'b0;
    else
      pready_q <= setup_ph;
  end

  // error flag and read data prepared during setup
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (setup_ph)
    begin
      pslverr_q <= ~is_mapped(paddr);
      prdata_q <= 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          lec_pkg::LEC_LUT_OFS: prdata_q[15:0] <= lut_mask_q;
          lec_pkg::LEC_MODE_OFS: prdata_q[8:0] <= mode_q;
          lec_pkg::LEC_STAT_OFS:
          begin
            // live view of the register, result and chain
            prdata_q[lec_pkg::LEC_ST_Q_BIT] <= q_q;
            prdata_q[lec_pkg::LEC_ST_COMB_BIT] <= comb_out;
            prdata_q[lec_pkg::LEC_ST_C0_BIT] <= carry_zero_path_out;
            prdata_q[lec_pkg::LEC_ST_C1_BIT] <= carry_one_path_out;
          end
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
    else if (pready_q)
    begin
      // clear after the access so stale data never lingers
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // configuration writes; status is read-only
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      lut_mask_q <= lec_pkg::LEC_LUT_RST;
      mode_q <= lec_pkg::LEC_MODE_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == lec_pkg::LEC_LUT_OFS)
        lut_mask_q <= pwdata[15:0];
      else if (paddr == lec_pkg::LEC_MODE_OFS)
        mode_q <= pwdata[8:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : lec_logic_cell
`default_nettype wire

// ===== hw/lec_pkg.sv
// constants shared by the logic cell and its bench
package lec_pkg;
  // apb register byte offsets
  localparam logic [7:0] LEC_LUT_OFS = 8'h00;
  localparam logic [7:0] LEC_MODE_OFS = 8'h04;
  localparam logic [7:0] LEC_STAT_OFS = 8'h08;
  // reset values
  localparam logic [15:0] LEC_LUT_RST = 16'h0000;
  localparam logic [8:0] LEC_MODE_RST = 9'h000;
  // mode register field positions
  localparam int LEC_FF_LSB = 0;
  localparam int LEC_ARITH_BIT = 2;
  localparam int LEC_FBK_BIT = 3;
  localparam int LEC_CHAIN_BIT = 4;
  localparam int LEC_PRESET_BIT = 5;
  localparam int LEC_SEL_LSB = 6;
  // status register field positions
  localparam int LEC_ST_Q_BIT = 0;
  localparam int LEC_ST_COMB_BIT = 1;
  localparam int LEC_ST_C0_BIT = 2;
  localparam int LEC_ST_C1_BIT = 3;
  // storage register behaviour
  typedef enum logic [1:0] {
    LEC_FF_D,
    LEC_FF_T,
    LEC_FF_JK,
    LEC_FF_SR
  } lec_ff_e;
endpackage : lec_pkg
